//--- common/ssf_pkg.sv
// Purpose: shared constants and types of the sensor sample buffer
// Assumes: one 50 MHz register clock, byte-wide frame storage
// Notes: register offsets are byte addresses on the AHB-Lite slave
package ssf_pkg;
    localparam int DEPTH = 512;
    localparam int PTR_W = 10;
    localparam int CNT_W = 12;
    localparam int FRAME_MAX = 7;
    localparam logic [PTR_W-1:0] FULL_ROOM = 10'h009;
    localparam logic [PTR_W-1:0] DEPTH_P = 10'h200;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_LEN_LO = 8'h08;
    localparam logic [7:0] OFF_LEN_HI = 8'h0C;
    localparam logic [7:0] OFF_DATA = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] CMD_FLUSH = 8'hB0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] FT_SENSOR = 2'h2;
    localparam logic [1:0] FT_CTRL = 2'h1;
    localparam logic [3:0] PAR_CFG_ERR = 4'h1;
    localparam logic [3:0] PAR_CFG_CHG = 4'h2;
    localparam logic [7:0] HDR_EMPTY = 8'h80;
    localparam logic [7:0] EMPTY_DATA = 8'h00;
    localparam logic [1:0] DSEL_FILT = 2'h1;
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_NORMAL = 2'h3;
    localparam logic [2:0] LEN_HDR = 3'h1;
    localparam logic [2:0] LEN_CHAN = 3'h3;
    localparam logic [2:0] LEN_CTRL = 3'h2;

    typedef struct packed {
        logic [2:0] sub;   // down-sampling exponent
        logic [1:0] dsel;  // data source select
        logic ten;         // store temperature
        logic pen;         // store pressure
        logic stop;        // stop on full
        logic mode;        // buffer enable
    } ssf_ctrl_t;
    localparam ssf_ctrl_t CTRL_RST = 9'h000;

    typedef struct packed {
        logic done;
        logic cfg_err;
        logic cfg_chg;
        logic [1:0] pwr;
        logic [23:0] t_raw;
        logic [23:0] p_raw;
        logic [23:0] t_filt;
        logic [23:0] p_filt;
    } ssf_meas_t;

    typedef enum logic [2:0] {
        W_IDLE = 3'b001,
        W_ROOM = 3'b010,
        W_FILL = 3'b100
    } ssf_wst_t;
endpackage

//--- hw/ssf_sync.sv
// Purpose: two-stage synchroniser for inputs from outside the clock domain
// Assumes: width set per instance
// Notes: only the second stage is visible to logic
`timescale 1ns/1ps
module ssf_sync #(
    parameter int W = 1
) (
    input wire logic clk,        // sampling clock
    input wire logic rst_n,      // synchronous reset
    input wire logic ce,         // clock enable
    input wire logic [W-1:0] d,  // asynchronous input
    output logic [W-1:0] q       // synchronised output
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // ssf_sync

//--- hw/ssf_dsmp.sv
// Purpose: power-of-two down-sampler for measurements entering the buffer
// Assumes: meas pulses one cycle per finished measurement
// Notes: outside normal mode every measurement is passed
`timescale 1ns/1ps
module ssf_dsmp (
    input wire logic clk,        // clock
    input wire logic rst_n,      // synchronous reset
    input wire logic ce,         // clock enable
    input wire logic normal,     // continuous mode active
    input wire logic restart,    // sleep to normal transition
    input wire logic meas,       // measurement finished
    input wire logic [2:0] sub,  // exponent of the factor
    output logic take            // this measurement is stored
);
    logic [6:0] cnt_q;
    logic [6:0] mask;
    assign mask = 7'((8'h01 << sub) - 8'h01);
    assign take = !normal || (cnt_q == 7'h00);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 7'h00;
        end else if (ce) begin
            if (restart) begin
                cnt_q <= 7'h00;
            end else if (meas && normal) begin
                cnt_q <= (cnt_q + 7'h01) & mask;
            end
        end
    end
endmodule // ssf_dsmp

//--- hw/ssf_top.sv
// Purpose: frame buffer of measurements for burst read-out over AHB-Lite
// Assumes: link data settles while MEAS_CLK is low and is taken at its rising edge
// Notes: one byte is stored per cycle; a read of the data register pops one byte
// Contract
// - 512 byte first-in first-out frame store
// - no frames stored when writing disabled
// - disabled buffer still readable and flushable
// - pressure and temperature stored independently
// - filtered data when source select is 01
// - byte count split high and low
// - count changes only on whole frames
// - count steps equal one frame length
// - down-sampling by two to the field
// - down-sampling only in normal mode
// - sleep to normal restarts down-sampling
// - reads never blocked nor blocking writes
// - data register address stays fixed
// - full when free space below nine
// - streaming drops oldest frames until fits
// - stop-on-full drops incoming frames
// - header: type, parameter, two zeros
// - header alone fixes frame length
// - sensor and control frame type codes
// - flush command empties the buffer
// - empty frames returned while drained
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module ssf_top (
    input wire logic REF_CLK,            // 50 MHz clock
    input wire logic RST_N,              // synchronous reset, active low
    input wire logic CE,                 // clock enable, freezes all state
    input wire logic HSEL,               // slave select
    input wire logic [31:0] HADDR,       // byte address
    input wire logic [1:0] HTRANS,       // transfer type
    input wire logic HWRITE,             // write transfer
    input wire logic [2:0] HSIZE,        // transfer size
    input wire logic [31:0] HWDATA,      // write data
    input wire logic HREADY,             // bus ready
    output logic [31:0] HRDATA,          // read data
    output logic HREADYOUT,              // slave ready
    output logic HRESP,                  // always okay
    input wire logic MEAS_CLK,           // link clock from measurement core
    input wire logic MEAS_DONE,          // measurement finished
    input wire logic MEAS_CFG_ERR,       // configuration error seen
    input wire logic MEAS_CFG_CHG,       // input configuration changed
    input wire logic [1:0] MEAS_PWR,     // power mode
    input wire logic [23:0] MEAS_T_RAW,  // unfiltered temperature
    input wire logic [23:0] MEAS_P_RAW,  // unfiltered pressure
    input wire logic [23:0] MEAS_T_FILT, // filtered temperature
    input wire logic [23:0] MEAS_P_FILT  // filtered pressure
);
    localparam int PTR_W = ssf_pkg::PTR_W;
    typedef logic [PTR_W-1:0] ptr_t;

    ssf_pkg::ssf_meas_t meas_in, meas_s;
    ssf_pkg::ssf_ctrl_t ctrl_q;
    ssf_pkg::ssf_wst_t wst_q;
    logic lclk_s, lclk_d_q, ledge;
    logic [7:0] ram [ssf_pkg::DEPTH];
    ptr_t wr_ptr_q, rd_ptr_q, count, room;
    logic [2:0] rd_off_q, wr_idx_q, len_q, rd_len;
    logic [7:0] frm_q [ssf_pkg::FRAME_MAX];
    logic empty_off_q, full, wr_en, acc, take, restart, normal;
    logic [1:0] pwr_d_q;
    logic err_pend_q, chg_pend_q, sens_pend_q, te_q, pe_q;
    logic [23:0] t_val_q, p_val_q;
    logic ap_q, ap_wr_q;
    logic [7:0] ap_addr_q;
    logic addr_ok, rd_req, pop, host_commit, discard, flush;
    logic [7:0] pop_byte;

    assign meas_in = {MEAS_DONE, MEAS_CFG_ERR, MEAS_CFG_CHG, MEAS_PWR,
                      MEAS_T_RAW, MEAS_P_RAW, MEAS_T_FILT, MEAS_P_FILT};

    ssf_sync #(.W(1)) u_sync_clk (
        .clk(REF_CLK), .rst_n(RST_N), .ce(CE), .d(MEAS_CLK), .q(lclk_s));
    ssf_sync #(.W($bits(ssf_pkg::ssf_meas_t))) u_sync_meas (
        .clk(REF_CLK), .rst_n(RST_N), .ce(CE), .d(meas_in), .q(meas_s));

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            lclk_d_q <= 1'b0;
            pwr_d_q <= ssf_pkg::MODE_SLEEP;
        end else if (CE) begin
            lclk_d_q <= lclk_s;
            if (ledge) begin
                pwr_d_q <= meas_s.pwr;
            end
        end
    end
    assign ledge = lclk_s && !lclk_d_q;
    assign normal = (meas_s.pwr == ssf_pkg::MODE_NORMAL);
    assign restart = ledge && normal && (pwr_d_q == ssf_pkg::MODE_SLEEP);

    ssf_dsmp u_dsmp (
        .clk(REF_CLK), .rst_n(RST_N), .ce(CE), .normal(normal),
        .restart(restart), .meas(ledge && meas_s.done), .sub(ctrl_q.sub), .take(take));

    assign wr_en = ctrl_q.mode && (ctrl_q.pen || ctrl_q.ten);
    assign acc = ledge && meas_s.done && wr_en && take;

    // pointers carry one wrap bit so a full store differs from an empty one
    assign count = wr_ptr_q - rd_ptr_q;
    assign room = ssf_pkg::DEPTH_P - count;
    assign full = room < ssf_pkg::FULL_ROOM;

    function automatic logic [2:0] frame_len(input logic [7:0] hdr);
        frame_len = ssf_pkg::LEN_HDR;
        if (hdr[7:6] == ssf_pkg::FT_SENSOR) begin
            frame_len = ssf_pkg::LEN_HDR + (hdr[4] ? ssf_pkg::LEN_CHAN : 3'h0)
                        + (hdr[2] ? ssf_pkg::LEN_CHAN : 3'h0);
        end else if (hdr[7:6] == ssf_pkg::FT_CTRL) begin
            frame_len = ssf_pkg::LEN_CTRL;
        end
    endfunction
    assign rd_len = frame_len(ram[rd_ptr_q[PTR_W-2:0]]);

    // capture of the chosen channels and source
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            t_val_q <= 24'h000000;
            p_val_q <= 24'h000000;
            te_q <= 1'b0;
            pe_q <= 1'b0;
        end else if (CE && acc) begin
            t_val_q <= (ctrl_q.dsel == ssf_pkg::DSEL_FILT) ? meas_s.t_filt : meas_s.t_raw;
            p_val_q <= (ctrl_q.dsel == ssf_pkg::DSEL_FILT) ? meas_s.p_filt : meas_s.p_raw;
            te_q <= ctrl_q.ten;
            pe_q <= ctrl_q.pen;
        end
    end

    // pending frames: a new event wins over the clear in the same cycle
    logic clr_err, clr_chg, clr_sens;
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            err_pend_q <= 1'b0;
            chg_pend_q <= 1'b0;
            sens_pend_q <= 1'b0;
        end else if (CE) begin
            err_pend_q <= (ledge && meas_s.cfg_err && wr_en) || (err_pend_q && !clr_err);
            chg_pend_q <= (ledge && meas_s.cfg_chg && wr_en) || (chg_pend_q && !clr_chg);
            sens_pend_q <= acc || (sens_pend_q && !clr_sens);
        end
    end

    // frame writer
    logic [1:0] kind_q;
    localparam logic [1:0] K_ERR = 2'h1;
    localparam logic [1:0] K_CHG = 2'h2;
    localparam logic [1:0] K_SENS = 2'h3;
    logic drop, go_fill, last_byte;
    assign drop = (wst_q == ssf_pkg::W_ROOM) && ctrl_q.stop && full;
    // one oldest frame per free cycle
    assign discard = (wst_q == ssf_pkg::W_ROOM) && !ctrl_q.stop && (room < ptr_t'(len_q))
                     && !host_commit && !flush;
    assign go_fill = (wst_q == ssf_pkg::W_ROOM) && !drop && (room >= ptr_t'(len_q));
    assign clr_err = (drop || go_fill) && (kind_q == K_ERR);
    assign clr_chg = (drop || go_fill) && (kind_q == K_CHG);
    assign clr_sens = (drop || go_fill) && (kind_q == K_SENS);
    assign last_byte = (wst_q == ssf_pkg::W_FILL) && (wr_idx_q == len_q - 3'h1);

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            wst_q <= ssf_pkg::W_IDLE;
            kind_q <= 2'h0;
            len_q <= ssf_pkg::LEN_HDR;
            wr_idx_q <= 3'h0;
            for (int i = 0; i < ssf_pkg::FRAME_MAX; i++) begin
                frm_q[i] <= 8'h00;
            end
        end else if (CE) begin
            unique case (wst_q)
                ssf_pkg::W_IDLE: begin
                    wr_idx_q <= 3'h0;
                    for (int i = 0; i < ssf_pkg::FRAME_MAX; i++) begin
                        frm_q[i] <= 8'h00;
                    end
                    // control frames carry their code again as opcode
                    if (err_pend_q) begin
                        kind_q <= K_ERR;
                        len_q <= ssf_pkg::LEN_CTRL;
                        frm_q[0] <= {ssf_pkg::FT_CTRL, ssf_pkg::PAR_CFG_ERR, 2'h0};
                        frm_q[1] <= {4'h0, ssf_pkg::PAR_CFG_ERR};
                        wst_q <= ssf_pkg::W_ROOM;
                    end else if (sens_pend_q && chg_pend_q) begin
                        kind_q <= K_CHG;
                        len_q <= ssf_pkg::LEN_CTRL;
                        frm_q[0] <= {ssf_pkg::FT_CTRL, ssf_pkg::PAR_CFG_CHG, 2'h0};
                        frm_q[1] <= {4'h0, ssf_pkg::PAR_CFG_CHG};
                        wst_q <= ssf_pkg::W_ROOM;
                    end else if (sens_pend_q) begin
                        kind_q <= K_SENS;
                        len_q <= frame_len({ssf_pkg::FT_SENSOR, 1'h0, te_q, 1'b0, pe_q, 2'h0});
                        frm_q[0] <= {ssf_pkg::FT_SENSOR, 1'h0, te_q, 1'b0, pe_q, 2'h0};
                        if (te_q) begin
                            frm_q[1] <= t_val_q[7:0];
                            frm_q[2] <= t_val_q[15:8];
                            frm_q[3] <= t_val_q[23:16];
                        end
                        if (pe_q) begin
                            frm_q[te_q ? 4 : 1] <= p_val_q[7:0];
                            frm_q[te_q ? 5 : 2] <= p_val_q[15:8];
                            frm_q[te_q ? 6 : 3] <= p_val_q[23:16];
                        end
                        wst_q <= ssf_pkg::W_ROOM;
                    end
                end
                ssf_pkg::W_ROOM: begin
                    if (drop) begin
                        wst_q <= ssf_pkg::W_IDLE;
                    end else if (go_fill) begin
                        wst_q <= ssf_pkg::W_FILL;
                    end
                end
                ssf_pkg::W_FILL: begin
                    wr_idx_q <= wr_idx_q + 3'h1;
                    if (last_byte) begin
                        wst_q <= ssf_pkg::W_IDLE;
                    end
                end
            endcase
        end
    end

    // byte store; pointer moves only at the last byte
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            wr_ptr_q <= '0;
        end else if (CE) begin
            if (wst_q == ssf_pkg::W_FILL) begin
                ram[(PTR_W-1)'(wr_ptr_q + ptr_t'(wr_idx_q))] <= frm_q[wr_idx_q];
            end
            if (last_byte) begin
                wr_ptr_q <= wr_ptr_q + ptr_t'(len_q);
            end
        end
    end

    // AHB-Lite address phase is captured, the data phase answers without wait
    assign addr_ok = HSEL && HREADY && (HTRANS == ssf_pkg::HTRANS_NONSEQ);
    // the data register sits at one fixed address
    assign rd_req = addr_ok && !HWRITE;
    assign pop = rd_req && (HADDR[7:0] == ssf_pkg::OFF_DATA);
    assign host_commit = pop && (count != '0) && (rd_off_q == rd_len - 3'h1);
    assign flush = ap_q && ap_wr_q && (ap_addr_q == ssf_pkg::OFF_CMD)
                   && (HWDATA[7:0] == ssf_pkg::CMD_FLUSH);
    // empty frame header then zero data
    assign pop_byte = (count == '0) ? (empty_off_q ? ssf_pkg::EMPTY_DATA : ssf_pkg::HDR_EMPTY)
                      : ram[(PTR_W-1)'(rd_ptr_q + ptr_t'(rd_off_q))];

    // read pointer steps by whole frames only
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rd_ptr_q <= '0;
            rd_off_q <= 3'h0;
            empty_off_q <= 1'b0;
        end else if (CE) begin
            if (flush) begin
                rd_ptr_q <= wr_ptr_q;
                rd_off_q <= 3'h0;
                empty_off_q <= 1'b0;
            end else if (discard) begin
                rd_ptr_q <= rd_ptr_q + ptr_t'(rd_len);
                rd_off_q <= 3'h0;
            end else if (pop && count == '0) begin
                empty_off_q <= !empty_off_q;
            end else if (pop) begin
                // reads proceed while the writer fills
                empty_off_q <= 1'b0;
                if (host_commit) begin
                    rd_ptr_q <= rd_ptr_q + ptr_t'(rd_len);
                    rd_off_q <= 3'h0;
                end else begin
                    rd_off_q <= rd_off_q + 3'h1;
                end
            end
        end
    end

    // control stays writable and readable while storing is off
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ap_q <= 1'b0;
            ap_wr_q <= 1'b0;
            ap_addr_q <= 8'h00;
            ctrl_q <= ssf_pkg::CTRL_RST;
            HRDATA <= 32'h00000000;
            HREADYOUT <= 1'b0;
            HRESP <= 1'b0;
        end else if (CE) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            ap_q <= addr_ok;
            ap_wr_q <= HWRITE;
            ap_addr_q <= HADDR[7:0];
            if (ap_q && ap_wr_q && ap_addr_q == ssf_pkg::OFF_CTRL) begin
                ctrl_q <= HWDATA[$bits(ssf_pkg::ssf_ctrl_t)-1:0];
            end
            if (rd_req) begin
                unique case (HADDR[7:0])
                    ssf_pkg::OFF_CTRL: HRDATA <= 32'(ctrl_q);
                    ssf_pkg::OFF_LEN_LO: HRDATA <= 32'(count[7:0]);
                    ssf_pkg::OFF_LEN_HI: HRDATA <= 32'(4'(ssf_pkg::CNT_W'(count) >> 8));
                    ssf_pkg::OFF_DATA: HRDATA <= 32'(pop_byte);
                    ssf_pkg::OFF_STATUS: HRDATA <= 32'({wr_en, count == '0, full});
                    default: HRDATA <= 32'h00000000;
                endcase
            end
        end
    end

    chk_wr_gate: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        CE && !wr_en && !sens_pend_q && !err_pend_q && !chg_pend_q
        |=> !sens_pend_q && !err_pend_q && !chg_pend_q)
        else $error("frame accepted while storing disabled");
    chk_commit_step: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        CE && last_byte && !pop && !flush |=> count == $past(count) + ptr_t'($past(len_q)))
        else $error("count step differs from frame length");
    chk_stop_drop: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        CE && drop |=> wst_q == ssf_pkg::W_IDLE && $stable(wr_ptr_q))
        else $error("frame stored while full in stop mode");
    chk_empty_read: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        CE && pop && count == '0 && !flush |=> HRDATA[7:0] == ssf_pkg::HDR_EMPTY
        || HRDATA[7:0] == ssf_pkg::EMPTY_DATA) else $error("drained read not empty frame");
    chk_flush_all: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        CE && flush |=> rd_ptr_q == $past(wr_ptr_q)) else $error("flush left frames");
    chk_hdr_zeros: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        wst_q == ssf_pkg::W_FILL |-> frm_q[0][1:0] == 2'h0) else $error("header low bits set");
    chk_src_filt: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        CE && acc && ctrl_q.dsel == ssf_pkg::DSEL_FILT |=> t_val_q == $past(meas_s.t_filt))
        else $error("unfiltered data with filter source");
    chk_wake_take: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        CE && restart |=> take) else $error("first measurement after wake not taken");
    chk_room_ok: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        wst_q == ssf_pkg::W_FILL |-> room >= ptr_t'(len_q))
        else $error("store overfilled");
endmodule // ssf_top

//--- tb/ssf_meas_model.sv
// Purpose: measurement core model driving the link side of the buffer
// Assumes: link clock period 160 ns, toggling only while an event is sent
// Notes: filtered values are the raw ones xor 0F0F0F
`timescale 1ns/1ps
module ssf_meas_model (
    output logic MEAS_CLK,           // link clock
    output logic MEAS_DONE,          // measurement finished
    output logic MEAS_CFG_ERR,       // configuration error event
    output logic MEAS_CFG_CHG,       // input configuration change event
    output logic [1:0] MEAS_PWR,     // power mode
    output logic [23:0] MEAS_T_RAW,  // raw temperature
    output logic [23:0] MEAS_P_RAW,  // raw pressure
    output logic [23:0] MEAS_T_FILT, // filtered temperature
    output logic [23:0] MEAS_P_FILT  // filtered pressure
);
    initial begin
        {MEAS_CLK, MEAS_DONE, MEAS_CFG_ERR, MEAS_CFG_CHG, MEAS_PWR} = 6'h00;
        {MEAS_T_RAW, MEAS_P_RAW, MEAS_T_FILT, MEAS_P_FILT} = {4{24'h5A5A5A}};
    end

    task automatic tick;
        #80 MEAS_CLK <= 1'h1;
        #80 MEAS_CLK <= 1'h0;
    endtask

    // a change event alone; its control frame waits for the next sensor frame
    task automatic change(input logic [1:0] pwr);
        MEAS_PWR <= pwr;
        tick();
        MEAS_CFG_CHG <= 1'h1;
        tick();
        MEAS_CFG_CHG <= 1'h0;
        repeat (3) tick();
    endtask

    // a mode edge comes first so a sleep to normal change is seen before the event
    task automatic send(input logic [1:0] pwr, input logic done, input logic err,
            input logic [23:0] t, input logic [23:0] p);
        MEAS_PWR <= pwr;
        tick();
        {MEAS_DONE, MEAS_CFG_ERR} <= {done, err};
        {MEAS_T_RAW, MEAS_P_RAW} <= {t, p};
        {MEAS_T_FILT, MEAS_P_FILT} <= {t, p} ^ {2{24'h0F0F0F}};
        tick();
        MEAS_DONE <= 1'h0;
        MEAS_CFG_ERR <= 1'h0;
        // hold time over: stale values must never pass for fresh ones
        {MEAS_T_RAW, MEAS_P_RAW, MEAS_T_FILT, MEAS_P_FILT} <=
            ~{MEAS_T_RAW, MEAS_P_RAW, MEAS_T_FILT, MEAS_P_FILT};
        repeat (3) tick();
    endtask
endmodule // ssf_meas_model

//--- tb/ssf_top_tb.sv
// Purpose: self-checking bench for the sensor sample buffer
// Assumes: one bus master, link events from the measurement model
// Notes: every scenario leaves the buffer empty for the next one
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error at %0t: got %h, expected %h", $time, g, e); end end
module ssf_top_tb;
    logic REF_CLK, RST_N, HWRITE, HREADYOUT, HRESP;
    logic MEAS_CLK, MEAS_DONE, MEAS_CFG_ERR, MEAS_CFG_CHG;
    logic [1:0] HTRANS, MEAS_PWR;
    logic [31:0] HADDR, HWDATA, HRDATA;
    logic [23:0] MEAS_T_RAW, MEAS_P_RAW, MEAS_T_FILT, MEAS_P_FILT;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;

    ssf_top DUT (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(1'h1), .HSEL(1'h1),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MEAS_CLK(MEAS_CLK), .MEAS_DONE(MEAS_DONE),
        .MEAS_CFG_ERR(MEAS_CFG_ERR), .MEAS_CFG_CHG(MEAS_CFG_CHG), .MEAS_PWR(MEAS_PWR),
        .MEAS_T_RAW(MEAS_T_RAW), .MEAS_P_RAW(MEAS_P_RAW),
        .MEAS_T_FILT(MEAS_T_FILT), .MEAS_P_FILT(MEAS_P_FILT));
    ssf_meas_model link (.MEAS_CLK(MEAS_CLK), .MEAS_DONE(MEAS_DONE),
        .MEAS_CFG_ERR(MEAS_CFG_ERR), .MEAS_CFG_CHG(MEAS_CFG_CHG), .MEAS_PWR(MEAS_PWR),
        .MEAS_T_RAW(MEAS_T_RAW),
        .MEAS_P_RAW(MEAS_P_RAW), .MEAS_T_FILT(MEAS_T_FILT), .MEAS_P_FILT(MEAS_P_FILT));

    initial begin
        REF_CLK = 1'h0;
        forever #10 REF_CLK = ~REF_CLK;
    end

    task automatic stop_test;
        $display("mismatches %0d, checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // the whole run needs under 8000 cycles
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        @(posedge REF_CLK);
        HADDR <= {24'h0, a};
        HWRITE <= w;
        HTRANS <= ssf_pkg::HTRANS_NONSEQ;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'h1);
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'h1);
        rd = HRDATA;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'h1, a, d, x);
    endtask

    task automatic rdb(input logic [7:0] e);
        logic [31:0] r;
        ahb(1'h0, ssf_pkg::OFF_DATA, 32'h0, r);
        `CHK(r, {24'h0, e})
        `CHK(HRESP, 1'h0)
    endtask

    // channel bytes leave least significant first
    task automatic rd3(input logic [23:0] v);
        rdb(v[7:0]);
        rdb(v[15:8]);
        rdb(v[23:16]);
    endtask

    task automatic cnt(input logic [11:0] e);
        logic [31:0] lo, hi;
        ahb(1'h0, ssf_pkg::OFF_LEN_LO, 32'h0, lo);
        ahb(1'h0, ssf_pkg::OFF_LEN_HI, 32'h0, hi);
        `CHK({hi[3:0], lo[7:0]}, e)
    endtask

    task automatic s_empty;
        cnt(12'h000);
        rdb(ssf_pkg::HDR_EMPTY);
        rdb(ssf_pkg::EMPTY_DATA);
        rdb(ssf_pkg::HDR_EMPTY);
    endtask

    task automatic s_disabled;
        wr(ssf_pkg::OFF_CTRL, 32'h01);
        link.send(2'h1, 1'h1, 1'h0, 24'h111111, 24'h222222);
        cnt(12'h000);
        wr(ssf_pkg::OFF_CTRL, 32'h0C);
        link.send(2'h1, 1'h1, 1'h0, 24'h111111, 24'h222222);
        cnt(12'h000);
    endtask

    task automatic s_both;
        wr(ssf_pkg::OFF_CTRL, 32'h0D);
        link.send(2'h1, 1'h1, 1'h0, 24'h123456, 24'hABCDEF);
        cnt(12'h007);
        rdb(8'h94);
        rd3(24'h123456);
        cnt(12'h007);
        rd3(24'hABCDEF);
        cnt(12'h000);
        wr(ssf_pkg::OFF_CTRL, 32'h09);
        link.send(2'h1, 1'h1, 1'h0, 24'h123456, 24'hABCDEF);
        rdb(8'h90);
        rd3(24'h123456);
    endtask

    task automatic s_filt;
        for (int k = 1; k < 3; k++) begin
            wr(ssf_pkg::OFF_CTRL, {26'h0, k[1:0], 4'h5});
            link.send(2'h1, 1'h1, 1'h0, 24'h0, 24'h314159);
            rdb(8'h84);
            rd3(k == 1 ? 24'h3E4E56 : 24'h314159);
        end
        wr(ssf_pkg::OFF_CTRL, 32'h05);
        link.send(2'h1, 1'h0, 1'h1, 24'h0, 24'h0);
        cnt(12'h002);
        rdb(8'h44);
        rdb(8'h01);
        link.change(2'h1);
        link.send(2'h1, 1'h1, 1'h0, 24'h0, 24'h000042);
        cnt(12'h006);
        rdb(8'h48);
        rdb(8'h02);
        rdb(8'h84);
        rd3(24'h000042);
    endtask

    // factor two after a sleep to normal change: first and third are kept
    task automatic s_dsmp;
        wr(ssf_pkg::OFF_CTRL, 32'h45);
        link.send(2'h0, 1'h0, 1'h0, 24'h0, 24'h0);
        repeat (4) link.send(2'h3, 1'h1, 1'h0, 24'h0, 24'h777777);
        cnt(12'h008);
        wr(ssf_pkg::OFF_CTRL, 32'h00);
        link.send(2'h3, 1'h1, 1'h0, 24'h0, 24'h777777);
        cnt(12'h008);
        rdb(8'h84);
        wr(ssf_pkg::OFF_CMD, {24'h0, ssf_pkg::CMD_FLUSH});
        cnt(12'h000);
    endtask

    // forced mode ignores the exponent; 126 frames of 4 leave 8 bytes free
    task automatic s_full;
        wr(ssf_pkg::OFF_CTRL, 32'h47);
        for (int i = 1; i <= 130; i++)
            link.send(2'h1, 1'h1, 1'h0, 24'h0, i[23:0]);
        cnt(12'h1F8);
        rdb(8'h84);
        rd3(24'h000001);
        cnt(12'h1F4);
        link.send(2'h1, 1'h1, 1'h0, 24'h0, 24'h000099);
        cnt(12'h1F8);
        // streaming: the third frame fits only after the oldest one is pushed out
        wr(ssf_pkg::OFF_CTRL, 32'h05);
        repeat (3) link.send(2'h1, 1'h1, 1'h0, 24'h0, 24'h0000AA);
        cnt(12'h200);
        rdb(8'h84);
        rd3(24'h000003);
        wr(ssf_pkg::OFF_CMD, {24'h0, ssf_pkg::CMD_FLUSH});
        cnt(12'h000);
    endtask

    initial begin
        RST_N = 1'h0;
        HTRANS = 2'h0;
        HADDR = 32'h0;
        HWRITE = 1'h0;
        HWDATA = 32'h0;
        repeat (20) @(posedge REF_CLK);
        RST_N <= 1'h1;
        repeat (2) @(posedge REF_CLK);
        s_empty();
        s_disabled();
        s_both();
        s_filt();
        s_dsmp();
        s_full();
        stop_test();
    end
endmodule // ssf_top_tb
